// ===== design/wdt_pkg.sv
package wdt_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses on the APB)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_RESET_CTRL = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_CLEAR = 8'h14;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_SOFT_EN = 5;
    localparam int BIT_TO_FLAG = 4;
    localparam int BIT_FIXED_EN = 7;
    localparam int BIT_WIN_DIS = 6;
    localparam int BIT_PRE_SEL = 4;
    localparam int BIT_CLEAR_CMD = 0;

    // ----------------------------------------------------------------
    // divider figures: period = n1 * n2 * tick * 16
    // ----------------------------------------------------------------
    localparam logic [4:0] LOG2_PRE_LOW = 5'h05;
    localparam logic [4:0] LOG2_PRE_HIGH = 5'h07;
    localparam logic [4:0] LOG2_FIXED16 = 5'h04;
    localparam int SLOW_CLK_NOMINAL_KHZ = 512;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CONFIG_RESET = 8'hDF;
    localparam logic [1:0] EVT_RESET = 2'h0;

    // configuration word, erased state is all ones
    typedef struct packed {
        logic fixed_watchdog_enable;
        logic window_disable;
        logic prescale_select;
        logic [3:0] postscale_select;
    } wdt_cfg_t;

    // sticky events, also the layout of the mask
    typedef struct packed {
        logic early_clear;
        logic timeout;
    } wdt_evt_t;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RUN = 2'b01
    } wdt_state_t;

endpackage

// ===== design/windowed_watchdog_timer.sv
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module windowed_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int CNT_W = 26
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic low_power_rc_clock,
    input wire logic power_save_instruction,
    input wire logic in_power_save,
    input wire logic clock_switch_done,
    input wire logic sys_reset_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic device_reset_req,
    output logic wake_req,
    output logic slow_clock_run,
    output logic irq
);

    // ----------------------------------------------------------------
    // reset release and clock sampling
    // ----------------------------------------------------------------
    logic rst_meta_r, rst_n;
    logic slow_meta_r, slow_sync_r, slow_prev_r;
    logic tick;

    // release is synchronous so no flop sees a partial reset edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // the slow clock is a pin, so it passes two flops first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_meta_r <= 1'b0;
            slow_sync_r <= 1'b0;
            slow_prev_r <= 1'b0;
        end else if (ce) begin
            slow_meta_r <= low_power_rc_clock;
            slow_sync_r <= slow_meta_r;
            slow_prev_r <= slow_sync_r;
        end
    end

    assign tick = slow_sync_r & ~slow_prev_r;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    // log2 of the whole period in slow ticks
    function automatic logic [4:0] period_log2(input wdt_cfg_t c);
        logic [4:0] pre;
        pre = c.prescale_select ? LOG2_PRE_HIGH : LOG2_PRE_LOW;
        return pre + LOG2_FIXED16 + {1'b0, c.postscale_select};
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wdt_state_t state_r, state_nxt;
    wdt_cfg_t cfg_r, cfg_nxt;
    wdt_evt_t stat_r, stat_nxt, mask_r, mask_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, limit, win_start;
    logic soft_r, soft_nxt, flag_r, flag_nxt;
    logic rst_req_r, rst_req_nxt, wake_r, wake_nxt;
    logic irq_r, irq_nxt, run_r, run_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic rdy_r, rdy_nxt, err_r, err_nxt;
    logic acc, wr, rd, mapped, clr_cmd;
    logic overflow, win_open, early, accepted;
    logic dev_reset;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // one wait state: data and ready come from flops
    assign acc = psel & penable & rdy_r;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign mapped = hit(paddr, OFS_RESET_CTRL) | hit(paddr, OFS_CONFIG)
        | hit(paddr, OFS_STATUS) | hit(paddr, OFS_MASK)
        | hit(paddr, OFS_COUNT) | hit(paddr, OFS_CLEAR);
    assign clr_cmd = wr & hit(paddr, OFS_CLEAR) & pwdata[BIT_CLEAR_CMD];

    // ----------------------------------------------------------------
    // period and window thresholds
    // ----------------------------------------------------------------
    // ratio two to code
    assign limit = ~({CNT_W{1'b1}} << period_log2(cfg_r));
    assign win_start = limit - (limit >> 2);
    assign win_open = cnt_r >= win_start;
    assign overflow = (state_r == ST_RUN) & tick & (cnt_r >= limit);
    assign early = clr_cmd & (state_r == ST_RUN) & ~cfg_r.window_disable
        & ~win_open;
    assign accepted = clr_cmd & ~early;
    // own reset request or one from elsewhere counts as a device reset
    assign dev_reset = sys_reset_in | rst_req_r;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cfg_nxt = cfg_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        soft_nxt = soft_r;
        flag_nxt = flag_r;
        cnt_nxt = cnt_r;
        rst_req_nxt = 1'b0;
        wake_nxt = 1'b0;
        // register writes
        if (wr) begin
            if (hit(paddr, OFS_RESET_CTRL)) begin
                soft_nxt = pwdata[BIT_SOFT_EN];
                if (!pwdata[BIT_TO_FLAG]) begin
                    flag_nxt = 1'b0;
                end
            end
            if (hit(paddr, OFS_CONFIG)) begin
                cfg_nxt = {pwdata[BIT_FIXED_EN], pwdata[BIT_WIN_DIS],
                           pwdata[BIT_PRE_SEL], pwdata[3:0]};
            end
            if (hit(paddr, OFS_MASK)) begin
                mask_nxt = pwdata[1:0];
            end
        end
        // status clears on read; new events below win
        if (rd && hit(paddr, OFS_STATUS)) begin
            stat_nxt = EVT_RESET;
        end
        if (dev_reset) begin
            soft_nxt = 1'b0;
        end
        if (cfg_r.fixed_watchdog_enable || soft_r) begin
            state_nxt = ST_RUN;
        end else begin
            state_nxt = ST_OFF;
        end
        if (state_r == ST_RUN && tick) begin
            cnt_nxt = cnt_r + 1'b1;
        end
        if (dev_reset || power_save_instruction || clock_switch_done
            || accepted || state_r != ST_RUN || overflow || early) begin
            cnt_nxt = '0;
        end
        if (overflow) begin
            if (in_power_save) begin
                wake_nxt = 1'b1;
            end else begin
                rst_req_nxt = 1'b1;
            end
        end
        if (early) begin
            rst_req_nxt = 1'b1;
            stat_nxt.early_clear = 1'b1;
        end
        // flag set wins over software clear
        if (overflow) begin
            flag_nxt = 1'b1;
            stat_nxt.timeout = 1'b1;
        end
        irq_nxt = |(stat_nxt & mask_nxt);
        run_nxt = (state_nxt == ST_RUN);
    end

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        rdy_nxt = 1'b0;
        err_nxt = 1'b0;
        if (psel && penable && !rdy_r) begin
            rdy_nxt = 1'b1;
            err_nxt = ~mapped;
            rdata_nxt = '0;
            if (hit(paddr, OFS_RESET_CTRL)) begin
                rdata_nxt[BIT_SOFT_EN] = soft_r;
                rdata_nxt[BIT_TO_FLAG] = flag_r;
            end
            if (hit(paddr, OFS_CONFIG)) begin
                rdata_nxt[BIT_FIXED_EN] = cfg_r.fixed_watchdog_enable;
                rdata_nxt[BIT_WIN_DIS] = cfg_r.window_disable;
                rdata_nxt[BIT_PRE_SEL] = cfg_r.prescale_select;
                rdata_nxt[3:0] = cfg_r.postscale_select;
            end
            if (hit(paddr, OFS_STATUS)) begin
                rdata_nxt[1:0] = stat_r;
            end
            if (hit(paddr, OFS_MASK)) begin
                rdata_nxt[1:0] = mask_r;
            end
            if (hit(paddr, OFS_COUNT)) begin
                rdata_nxt[CNT_W-1:0] = cnt_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // flag survives device resets; only power-on or a write of zero to its bit clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_OFF;
            cfg_r <= wdt_cfg_t'({CONFIG_RESET[7:6], CONFIG_RESET[4:0]});
            stat_r <= EVT_RESET;
            mask_r <= EVT_RESET;
            soft_r <= 1'b0;
            flag_r <= 1'b0;
            cnt_r <= '0;
            rst_req_r <= 1'b0;
            wake_r <= 1'b0;
            irq_r <= 1'b0;
            run_r <= 1'b0;
            rdata_r <= '0;
            rdy_r <= 1'b0;
            err_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            cfg_r <= cfg_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            soft_r <= soft_nxt;
            flag_r <= flag_nxt;
            cnt_r <= cnt_nxt;
            rst_req_r <= rst_req_nxt;
            wake_r <= wake_nxt;
            irq_r <= irq_nxt;
            run_r <= run_nxt;
            rdata_r <= rdata_nxt;
            rdy_r <= rdy_nxt;
            err_r <= err_nxt;
        end
    end

    assign prdata = rdata_r;
    assign pready = rdy_r;
    assign pslverr = err_r;
    assign device_reset_req = rst_req_r;
    assign wake_req = wake_r;
    assign slow_clock_run = run_r;
    assign irq = irq_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_timeout_reset: assert property (
        ce && overflow && !in_power_save |=> rst_req_r && !wake_r)
        else $error("timeout did not request reset");
    a_timeout_wake: assert property (
        ce && overflow && in_power_save |=> wake_r && !rst_req_r)
        else $error("timeout in power save did not wake");
    a_flag_set: assert property (
        ce && overflow |=> flag_r && stat_r.timeout)
        else $error("timeout flag not set");
    a_fixed_runs: assert property (
        ce && cfg_r.fixed_watchdog_enable |=> state_r == ST_RUN)
        else $error("fixed enable did not run watchdog");
    a_soft_gate: assert property (
        ce && !cfg_r.fixed_watchdog_enable && !soft_r |=> state_r == ST_OFF)
        else $error("watchdog ran without enable");
    a_reset_soft: assert property (
        ce && dev_reset |=> !soft_r)
        else $error("device reset kept soft enable");
    a_early_reset: assert property (
        ce && clr_cmd && state_r == ST_RUN && !cfg_r.window_disable
        && cnt_r < win_start |=> rst_req_r && cnt_r == '0)
        else $error("early clear did not reset");
    a_short_period: assert property (
        ce && overflow && !cfg_r.prescale_select
        && cfg_r.postscale_select == 4'h0 |-> cnt_r == 26'h1FF)
        else $error("shortest period is not 512 ticks");
    a_double_period: assert property (
        ce && overflow && !cfg_r.prescale_select
        && cfg_r.postscale_select == 4'h1 |-> cnt_r == 26'h3FF)
        else $error("postscale code one is not 1024 ticks");
    a_sleep_clear: assert property (
        ce && power_save_instruction |=> cnt_r == '0)
        else $error("power save entry did not clear counter");
    a_clock_alive: assert property (
        ce && (cfg_r.fixed_watchdog_enable || soft_r) |=> run_r)
        else $error("slow clock request dropped while enabled");

    c_timeout_reset: cover property (ce && overflow && !in_power_save);
    c_timeout_wake: cover property (ce && overflow && in_power_save);
    c_early_clear: cover property (ce && early);
    c_window_clear: cover property (
        ce && accepted && !cfg_r.window_disable && state_r == ST_RUN);

endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb
    import wdt_pkg::*;
;
    logic clk, arst_n, ce, low_power_rc_clock, power_save_instruction;
    logic in_power_save, clock_switch_done, sys_reset_in;
    logic psel, penable, pwrite, pready, pslverr;
    logic device_reset_req, wake_req, slow_clock_run, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic e, r, w, tick_en;
    logic [2:0] ph;
    int mismatches, checks_done, ticks, snap, cyc, seed, k;
    logic [7:0] cfgs [3] = '{8'h40, 8'h41, 8'h50};

    windowed_watchdog_timer windowed_watchdog_timer_i (
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .low_power_rc_clock(low_power_rc_clock),
        .power_save_instruction(power_save_instruction),
        .in_power_save(in_power_save),
        .clock_switch_done(clock_switch_done),
        .sys_reset_in(sys_reset_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .device_reset_req(device_reset_req), .wake_req(wake_req),
        .slow_clock_run(slow_clock_run), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // slow clock: 8 system cycles a tick, parked low when stopped
    always @(posedge clk) begin
        if (!tick_en) begin
            ph <= 3'h0;
            low_power_rc_clock <= 1'b0;
        end else begin
            ph <= ph + 3'h1;
            if (ph == 3'h3) begin
                low_power_rc_clock <= 1'b1;
                ticks <= ticks + 1;
            end
            if (ph == 3'h7) low_power_rc_clock <= 1'b0;
        end
    end

    // hang guard, well above the roughly 40k cycles of the tests
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            mismatches++;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        // access phase lasts two cycles: one wait state
        chk(n, 32'h2);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask

    // bounded wait for a reset or wake pulse
    task automatic wait_evt(input int lim);
        r = 1'b0;
        w = 1'b0;
        for (int n = 0; n < lim && !r && !w; n++) begin
            @(posedge clk);
            // values read here were launched at the previous edge
            r = device_reset_req;
            w = wake_req;
        end
    endtask

    function automatic logic [31:0] period(input logic [7:0] c);
        logic [31:0] p;
        p = c[BIT_PRE_SEL] ? 32'h80 : 32'h20;
        return (p * 32'h10) << c[3:0];
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {arst_n, power_save_instruction, in_power_save} = 3'b000;
        {clock_switch_done, sys_reset_in, tick_en} = 3'b000;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        seed = 22;
        ticks = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(OFS_CONFIG, 32'hDF);
        rd_chk(OFS_RESET_CTRL, 32'h0);
        chk({31'h0, slow_clock_run}, 32'h1);
        rd_chk(8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (k = 0; k < 6; k++) begin
            apb(1'b1, OFS_CONFIG, $random(seed));
            rd_chk(OFS_CONFIG, pwdata & 32'hDF);
        end
        apb(1'b1, OFS_CONFIG, 32'h40);
        repeat (2) @(posedge clk);
        chk({31'h0, slow_clock_run}, 32'h0);
        apb(1'b1, OFS_RESET_CTRL, 32'h20);
        repeat (2) @(posedge clk);
        chk({31'h0, slow_clock_run}, 32'h1);
        $display("test reset and config done");
        // counter clears: clock switch, power save entry, device reset
        for (k = 0; k < 3; k++) begin
            apb(1'b1, OFS_RESET_CTRL, 32'h20);
            snap = ticks;
            tick_en <= 1'b1;
            repeat (40 + 8 * k) @(posedge clk);
            tick_en <= 1'b0;
            rd_chk(OFS_COUNT, ticks - snap);
            @(posedge clk);
            case (k)
                0: clock_switch_done <= 1'b1;
                1: power_save_instruction <= 1'b1;
                default: sys_reset_in <= 1'b1;
            endcase
            @(posedge clk);
            {clock_switch_done, power_save_instruction} <= 2'b00;
            sys_reset_in <= 1'b0;
            rd_chk(OFS_COUNT, 32'h0);
        end
        rd_chk(OFS_RESET_CTRL, 32'h0);
        $display("test counter clear done");
        // time-out reset for several divider settings
        for (k = 0; k < 3; k++) begin
            apb(1'b1, OFS_CONFIG, cfgs[k]);
            apb(1'b1, OFS_MASK, 32'h1);
            apb(1'b1, OFS_RESET_CTRL, 32'h20);
            snap = ticks;
            tick_en <= 1'b1;
            wait_evt(20000);
            tick_en <= 1'b0;
            chk({30'h0, r, w}, 32'h2);
            chk(ticks - snap, period(cfgs[k]));
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h1);
            rd_chk(OFS_RESET_CTRL, 32'h10);
            rd_chk(OFS_STATUS, 32'h1);
            rd_chk(OFS_STATUS, 32'h0);
            chk({30'h0, irq, slow_clock_run}, 32'h0);
        end
        $display("test time-out reset done");
        // time-out while in power save wakes instead
        apb(1'b1, OFS_CONFIG, 32'h40);
        apb(1'b1, OFS_RESET_CTRL, 32'h20);
        in_power_save <= 1'b1;
        power_save_instruction <= 1'b1;
        @(posedge clk);
        power_save_instruction <= 1'b0;
        snap = ticks;
        tick_en <= 1'b1;
        wait_evt(20000);
        tick_en <= 1'b0;
        in_power_save <= 1'b0;
        chk({30'h0, r, w}, 32'h1);
        chk(ticks - snap, 32'd512);
        rd_chk(OFS_RESET_CTRL, 32'h30);
        $display("test wake done");
        // window mode: early clear resets, late clear accepted
        apb(1'b1, OFS_CONFIG, 32'h00);
        apb(1'b1, OFS_MASK, 32'h3);
        // wake left the timeout bit standing; reading clears it
        rd_chk(OFS_STATUS, 32'h1);
        apb(1'b1, OFS_RESET_CTRL, 32'h20);
        snap = ticks;
        tick_en <= 1'b1;
        repeat (100) @(posedge clk);
        tick_en <= 1'b0;
        apb(1'b1, OFS_CLEAR, 32'h1);
        wait_evt(6);
        chk({30'h0, r, w}, 32'h2);
        rd_chk(OFS_STATUS, 32'h2);
        apb(1'b1, OFS_RESET_CTRL, 32'h20);
        snap = ticks;
        tick_en <= 1'b1;
        while (ticks - snap < 400) @(posedge clk);
        tick_en <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b1, OFS_CLEAR, 32'h1);
        wait_evt(6);
        chk({30'h0, r, w}, 32'h0);
        rd_chk(OFS_COUNT, 32'h0);
        rd_chk(OFS_RESET_CTRL, 32'h20);
        $display("test window done");
        // clock enable low: slow ticks must not reach the counter
        ce <= 1'b0;
        tick_en <= 1'b1;
        repeat (40) @(posedge clk);
        tick_en <= 1'b0;
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(OFS_COUNT, 32'h0);
        $display("test clock enable done");
        summarize();
    end
endmodule
